// >>> lfd_regs.sv
`timescale 1ns/1ps
`include "lfd_defines.svh"

module lfd_regs #(
  parameter int ADDR_W = 12,
  parameter int SENSE_W = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // APB slave
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Operating conditions
  input wire logic lightLoad,
  input wire logic [1:0] senseRange,
  input wire logic [SENSE_W-1:0] senseLevel,
  input wire logic [7:0] normLowGain,
  // Filter and dead-time controls
  output lfd_pkg::lfd_coef_t coef,
  output logic deadtimeOffsetEn
);

  localparam int NREG = `LFD_NUM_REGS;

  // Register bank
  logic [7:0] regs_q [NREG];

  // Bus handshake state
  lfd_pkg::lfd_state_t state_q;
  lfd_pkg::lfd_state_t state_d;
  logic pready_q;
  logic pslverr_q;
  logic pslverr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  // Outputs to the loop
  lfd_pkg::lfd_coef_t coef_q;
  lfd_pkg::lfd_coef_t coef_d;
  logic offsetEn_q;

  // Address decode
  wire logic [`LFD_IDX_W-1:0] wordIdx =
    paddr[`LFD_WORD_LSB +: `LFD_IDX_W];
  wire logic [`LFD_IDX_W-1:0] relIdx =
    `LFD_IDX_W'(wordIdx - `LFD_IDX_FIRST);
  wire logic upperZero =
    (paddr >> (`LFD_WORD_LSB + `LFD_IDX_W)) == '0;
  wire logic aligned = paddr[1:0] == `LFD_ALIGN_OK;
  wire logic inRange = wordIdx >= `LFD_IDX_FIRST &&
    relIdx < `LFD_IDX_W'(NREG);
  wire logic regHit = inRange && aligned && upperZero;
  wire logic [2:0] regSel = relIdx[2:0];

  // Access phase seen for the first time
  wire logic accStart = psel && penable &&
    state_q == lfd_pkg::LFD_ST_IDLE;
  // Transfer completes at this edge
  wire logic accDone = psel && penable && pready_q;
  wire logic wrEn = accDone && pwrite && regHit && !pslverr_q &&
    pstrb[0];
  wire logic [7:0] rdByte = regs_q[regSel];

  // Named views of the bank
  wire logic [7:0] normZero = regs_q[`LFD_POS_NORM_ZERO];
  wire logic [7:0] normPole = regs_q[`LFD_POS_NORM_POLE];
  wire logic [7:0] normHigh = regs_q[`LFD_POS_NORM_HIGH];
  wire logic [7:0] lightLow = regs_q[`LFD_POS_LIGHT_LOW];
  wire logic [7:0] lightZero = regs_q[`LFD_POS_LIGHT_ZERO];
  wire logic [7:0] lightPole = regs_q[`LFD_POS_LIGHT_POLE];
  wire logic [7:0] lightHigh = regs_q[`LFD_POS_LIGHT_HIGH];
  wire logic [7:0] dtThresh = regs_q[`LFD_POS_DT_THRESH];
  wire logic [2:0] thrCode = dtThresh[`LFD_THR_MSB:`LFD_THR_LSB];

  // One wait state: pready rises in the second access cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      lfd_pkg::LFD_ST_IDLE: begin
        if (accStart) begin
          state_d = lfd_pkg::LFD_ST_ACK;
        end
      end
      lfd_pkg::LFD_ST_ACK: begin
        state_d = lfd_pkg::LFD_ST_IDLE;
      end
      default: begin
        state_d = lfd_pkg::LFD_ST_IDLE;
      end
    endcase
  end

  // Read data and error captured with the answer
  always_comb begin
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    if (accStart) begin
      prdata_d = `LFD_RST_WORD;
      pslverr_d = !regHit;
      if (regHit && !pwrite) begin
        prdata_d = {24'h00_0000, rdByte};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= lfd_pkg::LFD_ST_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= `LFD_RST_WORD;
    end else begin
      state_q <= state_d;
      pready_q <= accStart;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // Each byte register, reserved bits included, is plain read/write
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : gReg
      wire logic selMe = wrEn && regSel == 3'(gi);
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          regs_q[gi] <= `LFD_RST_REG;
        end else if (selMe) begin
          regs_q[gi] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  // Coefficient set follows the load mode
  always_comb begin
    if (lightLoad) begin
      coef_d.lowGain = lightLow;
      coef_d.zero = lightZero;
      coef_d.pole = lightPole;
      coef_d.highGain = lightHigh;
    end else begin
      coef_d.lowGain = normLowGain;
      coef_d.zero = normZero;
      coef_d.pole = normPole;
      coef_d.highGain = normHigh;
    end
  end

  // Threshold level and comparison
  logic [SENSE_W-1:0] thrLevel;
  logic belowThr;

  lfd_thresh #(
    .SENSE_W(SENSE_W)
  ) uThresh (
    .thrCode(thrCode),
    .senseRange(senseRange),
    .senseLevel(senseLevel),
    .thrLevel(thrLevel),
    .belowThr(belowThr)
  );

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      coef_q <= '0;
      offsetEn_q <= 1'b0;
    end else begin
      coef_q <= coef_d;
      offsetEn_q <= belowThr;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign coef = coef_q;
  assign deadtimeOffsetEn = offsetEn_q;

  // Checks stay off until one edge after reset release
  logic chkArm_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      chkArm_q <= 1'b0;
    end else begin
      chkArm_q <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn || !chkArm_q);

  AST_NORM_ZERO_WR: assert property (
    wrEn && regSel == 3'(`LFD_POS_NORM_ZERO) ##1 !lightLoad
    |=> coef.zero == $past(pwdata[7:0], 2))
    else $error("normal zero write not applied to filter");

  AST_NORM_ZERO_LAND: assert property (
    wrEn && regSel == 3'(`LFD_POS_NORM_ZERO)
    |=> normZero == $past(pwdata[7:0]))
    else $error("normal zero write not stored");

  AST_NORM_ZERO_SEL: assert property (
    !lightLoad |=> coef.zero == $past(normZero))
    else $error("normal zero not routed");

  AST_NORM_POLE_WR: assert property (
    wrEn && regSel == 3'(`LFD_POS_NORM_POLE)
    |=> normPole == $past(pwdata[7:0]))
    else $error("normal pole write not stored");

  AST_NORM_HIGH_WR: assert property (
    wrEn && regSel == 3'(`LFD_POS_NORM_HIGH)
    |=> normHigh == $past(pwdata[7:0]))
    else $error("normal high gain write not stored");

  AST_LIGHT_LOW_WR: assert property (
    wrEn && regSel == 3'(`LFD_POS_LIGHT_LOW)
    |=> lightLow == $past(pwdata[7:0]))
    else $error("light load low gain write not stored");

  AST_LIGHT_ZERO_WR: assert property (
    wrEn && regSel == 3'(`LFD_POS_LIGHT_ZERO)
    |=> lightZero == $past(pwdata[7:0]))
    else $error("light load zero write not stored");

  AST_LIGHT_POLE_WR: assert property (
    wrEn && regSel == 3'(`LFD_POS_LIGHT_POLE)
    |=> lightPole == $past(pwdata[7:0]))
    else $error("light load pole write not stored");

  AST_LIGHT_POLE_SEL: assert property (
    lightLoad |=> coef.pole == $past(lightPole))
    else $error("light load pole not routed");

  AST_LIGHT_HIGH_WR: assert property (
    wrEn && regSel == 3'(`LFD_POS_LIGHT_HIGH)
    |=> lightHigh == $past(pwdata[7:0]))
    else $error("light load high gain write not stored");

  AST_STROBE_OFF: assert property (
    accDone && pwrite && !pstrb[0] && regSel == 3'(`LFD_POS_NORM_ZERO)
    |=> $stable(normZero))
    else $error("write without low strobe changed a register");

  AST_THR_ZERO_LVL: assert property (
    thrCode == `LFD_THR_ZERO |-> thrLevel == '0)
    else $error("threshold code zero gives a nonzero level");

  AST_THR_LVL_ON: assert property (
    thrCode != `LFD_THR_ZERO |-> thrLevel != '0)
    else $error("nonzero threshold code gives a zero level");

  AST_WAIT_STATE: assert property (
    accStart |=> pready)
    else $error("answer not given after one wait state");

  AST_PREADY_PULSE: assert property (
    pready |=> !pready)
    else $error("ready held longer than one cycle");

  AST_RD_UPPER_ZERO: assert property (
    pready |-> prdata[`LFD_DATA_W-1:`LFD_REG_W] == '0)
    else $error("read data upper bits not zero");

  AST_ERR_RD_ZERO: assert property (
    pready && pslverr |-> prdata == `LFD_RST_WORD)
    else $error("refused access returned data");

  AST_NORM_POLE_RD: assert property (
    accStart && !pwrite && regHit
    && regSel == 3'(`LFD_POS_NORM_POLE)
    |=> pready && prdata == {24'h00_0000, $past(normPole)})
    else $error("normal pole read back wrong");

  AST_NORM_HIGH: assert property (
    !lightLoad |=> coef.highGain == $past(normHigh))
    else $error("normal high gain not routed");

  AST_LIGHT_LOW: assert property (
    lightLoad |=> coef.lowGain == $past(lightLow))
    else $error("light load low gain not routed");

  AST_LIGHT_ZERO: assert property (
    lightLoad |=> coef.zero == $past(lightZero))
    else $error("light load zero not routed");

  AST_LIGHT_POLE_HOLD: assert property (
    !wrEn |=> $stable(lightPole))
    else $error("light load pole changed without a write");

  AST_LIGHT_HIGH: assert property (
    lightLoad ##1 lightLoad |-> coef.highGain == $past(lightHigh))
    else $error("light load high gain not routed");

  AST_THRESH_RSV_RW: assert property (
    wrEn && regSel == 3'(`LFD_POS_DT_THRESH)
    |=> dtThresh == $past(pwdata[7:0]))
    else $error("threshold reserved bits not kept");

  AST_OFFSET_EN: assert property (
    1'b1 |=> deadtimeOffsetEn ==
      ($past(senseLevel) < $past(thrLevel)))
    else $error("offset enable disagrees with compare");

  AST_CODE_ZERO: assert property (
    thrCode == `LFD_THR_ZERO |=> !deadtimeOffsetEn)
    else $error("offsets applied at threshold code zero");

  AST_NORM_SET: assert property (
    !lightLoad |=> coef.lowGain == $past(normLowGain)
      && coef.pole == $past(normPole))
    else $error("normal set not selected");

  AST_ERR_UNMAPPED: assert property (
    accStart && !regHit |=> pready && pslverr)
    else $error("unmapped access not flagged");

  COV_WRITE: cover property (wrEn);
  COV_READ: cover property (accDone && !pwrite && !pslverr);
  COV_MODE_SWAP: cover property (!lightLoad ##1 lightLoad);
  COV_OFFSET_ON: cover property ($rose(deadtimeOffsetEn));
  COV_ERROR: cover property (pready && pslverr);

endmodule

// >>> lfd_defines.svh
`ifndef LFD_DEFINES_SVH
`define LFD_DEFINES_SVH

// Bus geometry
`define LFD_DATA_W 32
`define LFD_REG_W 8
`define LFD_WORD_LSB 2
`define LFD_IDX_W 7
`define LFD_ALIGN_OK 2'h0

// Register indexes; byte address is four times the index
`define LFD_IDX_NORM_ZERO 7'h61
`define LFD_IDX_NORM_POLE 7'h62
`define LFD_IDX_NORM_HIGH 7'h63
`define LFD_IDX_LIGHT_LOW 7'h64
`define LFD_IDX_LIGHT_ZERO 7'h65
`define LFD_IDX_LIGHT_POLE 7'h66
`define LFD_IDX_LIGHT_HIGH 7'h67
`define LFD_IDX_DT_THRESH 7'h68
`define LFD_IDX_FIRST 7'h61
`define LFD_NUM_REGS 8

// Position of each register within the bank
`define LFD_POS_NORM_ZERO 0
`define LFD_POS_NORM_POLE 1
`define LFD_POS_NORM_HIGH 2
`define LFD_POS_LIGHT_LOW 3
`define LFD_POS_LIGHT_ZERO 4
`define LFD_POS_LIGHT_POLE 5
`define LFD_POS_LIGHT_HIGH 6
`define LFD_POS_DT_THRESH 7

// Reset values
`define LFD_RST_REG 8'h00
`define LFD_RST_WORD 32'h0000_0000

// Threshold field layout
`define LFD_THR_MSB 2
`define LFD_THR_LSB 0
`define LFD_THR_ZERO 3'h0

// Gain scale: 0.3 dB per step over 20 dB, in millidecibels
`define LFD_GAIN_STEP_MDB 300
`define LFD_GAIN_SPAN_MDB 20000

`endif

// >>> lfd_pkg.sv
package lfd_pkg;

  typedef enum logic [1:0] {
    LFD_RNG_37M5 = 2'h0,
    LFD_RNG_75M = 2'h1,
    LFD_RNG_150M = 2'h2
  } lfd_range_t;

  typedef enum logic [1:0] {
    LFD_ST_IDLE = 2'h0,
    LFD_ST_ACK = 2'h1
  } lfd_state_t;

  typedef struct packed {
    logic [7:0] lowGain;
    logic [7:0] zero;
    logic [7:0] pole;
    logic [7:0] highGain;
  } lfd_coef_t;

endpackage

// >>> lfd_thresh.sv
`timescale 1ns/1ps
`include "lfd_defines.svh"

module lfd_thresh #(
  parameter int SENSE_W = 16
) (
  // Threshold setting
  input wire logic [2:0] thrCode,
  input wire logic [1:0] senseRange,
  // Sensed current, 10 uV units
  input wire logic [SENSE_W-1:0] senseLevel,
  // Result
  output logic [SENSE_W-1:0] thrLevel,
  output logic belowThr
);

  // Threshold levels per range, 10 uV units
  localparam logic [15:0] LVL_37M5 [8] = '{
    16'h0000, 16'h0186, 16'h030C, 16'h0492,
    16'h060E, 16'h079E, 16'h092E, 16'h0A8C};
  localparam logic [15:0] LVL_75M [8] = '{
    16'h0000, 16'h030C, 16'h0618, 16'h092E,
    16'h0C1C, 16'h0F3C, 16'h125C, 16'h1518};
  localparam logic [15:0] LVL_150M [8] = '{
    16'h0000, 16'h0618, 16'h0C35, 16'h125C,
    16'h186A, 16'h1E78, 16'h24B8, 16'h2A94};

  wire logic [15:0] lvl37 = LVL_37M5[thrCode];
  wire logic [15:0] lvl75 = LVL_75M[thrCode];
  wire logic [15:0] lvl150 = LVL_150M[thrCode];
  wire logic isR37 = senseRange == lfd_pkg::LFD_RNG_37M5;
  wire logic isR75 = senseRange == lfd_pkg::LFD_RNG_75M;

  // Level scales with the current-sense range; code zero is zero
  wire logic [15:0] lvlSel =
    isR37 ? lvl37 : (isR75 ? lvl75 : lvl150);

  assign thrLevel = SENSE_W'(lvlSel);
  // Offsets apply strictly below the level
  assign belowThr = senseLevel < thrLevel;

endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
  n_compared++; \
  if ((got) !== (ex)) begin \
    n_errors++; \
    $display("[ERR] %s exp %0h got %0h", nm, ex, got); \
  end \
end

module tb_top;
  // Clock and reset
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  // APB master side
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // Loop side
  logic lightLoad = 1'b0;
  logic [1:0] senseRange = 2'h0;
  logic [15:0] senseLevel = 16'h0000;
  logic [7:0] normLowGain = 8'h00;
  lfd_pkg::lfd_coef_t coef;
  logic deadtimeOffsetEn;
  // Bench state
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] rdat;
  logic rerr;
  // Threshold levels in 10 uV units, per range and code
  int lv [3][8] = '{'{0, 390, 780, 1170, 1550, 1950, 2350, 2700},
                    '{0, 780, 1560, 2350, 3100, 3900, 4700, 5400},
                    '{0, 1560, 3125, 4700, 6250, 7800, 9400, 10900}};

  lfd_regs dut_u (
    .clk_sys(clk_sys), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lightLoad(lightLoad), .senseRange(senseRange),
    .senseLevel(senseLevel), .normLowGain(normLowGain), .coef(coef),
    .deadtimeOffsetEn(deadtimeOffsetEn)
  );

  always #25 clk_sys = ~clk_sys;

  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One APB transfer; read data and error taken at the pready edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle();
    repeat (2) @(posedge clk_sys);
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    // Reset values, then write and read back every register
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 12'h184 + 12'(4 * i), 32'h0, 4'hF);
      `CHK("reset value", 32'h0000_0000, rdat)
    end
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 12'h184 + 12'(4 * i), 32'hFFFF_FF00 | (8'h11 * (i + 1)),
          4'hF);
      `CHK("write error", 1'b0, rerr)
    end
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 12'h184 + 12'(4 * i), 32'h0, 4'hF);
      `CHK("readback", 32'(8'h11 * (i + 1)), rdat)
    end
    $display("Test registers done");
    // Refused accesses
    apb(1'b0, 12'h180, 32'h0, 4'hF);
    `CHK("unmapped err", 1'b1, rerr)
    `CHK("unmapped data", 32'h0000_0000, rdat)
    apb(1'b1, 12'h185, 32'h0000_00EE, 4'hF);
    `CHK("unaligned err", 1'b1, rerr)
    apb(1'b1, 12'h184, 32'h0000_00EE, 4'hE);
    apb(1'b0, 12'h184, 32'h0, 4'hF);
    `CHK("strobe off", 32'h0000_0011, rdat)
    $display("Test refusals done");
    // Coefficient set selection
    normLowGain <= 8'hC3;
    settle();
    `CHK("normal set", 32'hC311_2233, coef)
    lightLoad <= 1'b1;
    settle();
    `CHK("light set", 32'h4455_6677, coef)
    apb(1'b1, 12'h198, 32'h0000_005A, 4'hF);
    settle();
    `CHK("light pole", 32'h4455_5A77, coef)
    lightLoad <= 1'b0;
    settle();
    `CHK("normal again", 32'hC311_2233, coef)
    $display("Test coefficients done");
    // Threshold against every code and range, reserved bits set
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 12'h1A0, 32'h0000_00F8 | c, 4'hF);
      for (int r = 0; r < 4; r++) begin
        senseRange <= 2'(r);
        senseLevel <= 16'(lv[(r == 3) ? 2 : r][c]);
        settle();
        `CHK("at level", 1'b0, deadtimeOffsetEn)
        if (c != 0) begin
          senseLevel <= 16'(lv[(r == 3) ? 2 : r][c] - 1);
          settle();
          `CHK("below level", 1'b1, deadtimeOffsetEn)
        end
      end
    end
    $display("Test threshold done");
    // Second reset in mid-run
    rstn <= 1'b0;
    @(posedge clk_sys);
    `CHK("reset coef", 32'h0000_0000, coef)
    `CHK("reset enable", 1'b0, deadtimeOffsetEn)
    rstn <= 1'b1;
    apb(1'b0, 12'h1A0, 32'h0, 4'hF);
    `CHK("reset thresh", 32'h0000_0000, rdat)
    $display("Test reset done");
    stop_test();
  end
endmodule
